// ### irq_standby_pkg.sv
package irq_standby_pkg;

  // source count, vector count, level codes
  localparam int NUM_SOURCES = 28;
  localparam int NUM_VECTORS = 10;
  localparam int VEC_W = 4;
  localparam int SRC_W = 5;
  localparam logic [1:0] LVL_NONE = 2'h0;
  localparam logic [1:0] LVL_LOW = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;
  localparam logic [1:0] SRV_RESET = 2'h0;

  // vector base address and spacing
  localparam logic [19:0] VEC_BASE = 20'h00003;
  localparam logic [19:0] VEC_STEP = 20'h00008;

  // source indices
  localparam int S_PIN_A = 0;
  localparam int S_PIN_B = 1;
  localparam int S_PIN_C = 2;
  localparam int S_T0L = 3;
  localparam int S_GRP_E = 4;
  localparam int S_USB_ACT = 5;
  localparam int S_RMT = 6;
  localparam int S_PIN_D = 7;
  localparam int S_GRP_F = 8;
  localparam int S_BTMR = 9;
  localparam int S_T0H = 10;
  localparam int S_T1L = 11;
  localparam int S_T1H = 12;
  localparam int S_SSP_A = 13;
  localparam int S_USB_RST = 14;
  localparam int S_USB_SUSP = 15;
  localparam int S_UART_RX = 16;
  localparam int S_ASP = 17;
  localparam int S_USB_EP = 18;
  localparam int S_USB_SOF = 19;
  localparam int S_SSP_CRC = 20;
  localparam int S_UART_TX = 21;
  localparam int S_ADC = 22;
  localparam int S_T6 = 23;
  localparam int S_T7 = 24;
  localparam int S_PORT0 = 25;
  localparam int S_PWM0 = 26;
  localparam int S_PWM1 = 27;

  // vector index of each source
  localparam logic [NUM_SOURCES*VEC_W-1:0] SRC_VEC_MAP = {
    4'h9, 4'h9, 4'h9, 4'h8, 4'h8, 4'h8, 4'h7, 4'h7, 4'h7, 4'h7, 4'h7,
    4'h6, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h4, 4'h3, 4'h3, 4'h3,
    4'h2, 4'h2, 4'h2, 4'h2, 4'h2, 4'h1, 4'h0};

  // wake masks per standby mode
  localparam logic [NUM_SOURCES-1:0] HOLD_WAKE_MASK = 28'h2000137;
  localparam logic [NUM_SOURCES-1:0] XHOLD_WAKE_MASK = 28'h2000377;

  typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_HOLD, MODE_XHOLD} standby_mode_e;

  // grant toward the core
  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vec;
    logic [1:0] lvl;
    logic [19:0] addr;
  } grant_s;

  // oscillator run enables
  typedef struct packed {
    logic pll_run;
    logic ceramic_oscillator_run;
    logic internal_rc_oscillator_run;
    logic xtal_run;
  } osc_s;

endpackage : irq_standby_pkg

// ### irq_arbiter.sv
`timescale 1ns/100ps
module irq_arbiter
  import irq_standby_pkg::*;
(
  input wire logic [NUM_VECTORS-1:0] vec_pend,
  input wire logic [NUM_VECTORS-1:0] vec_hi,
  input wire logic [1:0] srv_lvl,
  output logic grant_ok,
  output logic [VEC_W-1:0] grant_vec,
  output logic [1:0] grant_lvl
);

  logic [1:0] lvl_of [NUM_VECTORS];

  // level of each vector: first two may be top, others high
  genvar g;
  generate
    for (g = 0; g < NUM_VECTORS; g++) begin : g_lvl
      if (g < 2) begin : g_top
        assign lvl_of[g] = vec_hi[g] ? LVL_TOP : LVL_LOW;
      end else begin : g_hi
        assign lvl_of[g] = vec_hi[g] ? LVL_HIGH : LVL_LOW;
      end
    end
  endgenerate

  // highest level wins, smallest vector within a level; must beat service level
  always_comb begin
    grant_ok = 1'b0;
    grant_vec = '0;
    grant_lvl = LVL_NONE;
    for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
      if (vec_pend[i] && lvl_of[i] >= grant_lvl && lvl_of[i] > srv_lvl) begin // RQ2 RQ1
        grant_ok = 1'b1;
        grant_vec = VEC_W'(i);
        grant_lvl = lvl_of[i];
      end
    end
  end

endmodule : irq_arbiter

// ### irq_standby.sv
`timescale 1ns/100ps
// How it works
// [RQ1] three nested levels; requests at or below service level are refused
// [RQ2] grant highest level, then smallest vector address
// [RQ3] 28 sources fold onto 10 vectors
// [RQ4] vector 13H: pin c, timer zero low, group e, usb active, remote
// [RQ5] vector 33H: serial port a, usb reset, usb suspend, uart receive
// [RQ6] halt stops execution only, peripherals and oscillators keep running
// [RQ7] halt ends on reset or any interrupt request
// [RQ8] hold stops execution, peripherals, pll and all oscillators
// [RQ9] hold wakes on reset pin, pins a b c, groups e f, port0, usb active
// [RQ10] crystal hold stops pll, ceramic, rc; crystal kept; remote keeps running
// [RQ11] crystal hold adds base timer and remote receiver wakes
// [RQ12] waking source also posts its request to the arbiter
module irq_standby
  import irq_standby_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [NUM_SOURCES-1:0] src_req,
  input wire logic [NUM_VECTORS-1:0] vec_hi,
  input wire logic ack,
  input wire logic reti,
  input wire logic enter_halt,
  input wire logic enter_hold,
  input wire logic enter_xhold,
  output grant_s grant,
  output osc_s osc,
  output logic cpu_run,
  output logic periph_run,
  output logic remote_run,
  output standby_mode_e mode
);

  logic [NUM_SOURCES-1:0] src_pend_reg;
  logic [NUM_VECTORS-1:0] vec_pend;
  logic [1:0] srv_stack_reg [3];
  logic [1:0] depth_reg;
  logic [1:0] srv_lvl;
  logic arb_ok;
  logic [VEC_W-1:0] arb_vec;
  logic [1:0] arb_lvl;
  logic xtal_keep_reg;
  logic wake;
  logic [NUM_SOURCES-1:0] wake_mask;
  logic take;

  // fold sources onto vectors
  genvar g;
  generate
    for (g = 0; g < NUM_VECTORS; g++) begin : g_fold
      logic [NUM_SOURCES-1:0] hit;
      for (genvar s = 0; s < NUM_SOURCES; s++) begin : g_s
        assign hit[s] = src_pend_reg[s] && (SRC_VEC_MAP[s*VEC_W +: VEC_W] == VEC_W'(g)); // RQ3 RQ4 RQ5
      end
      assign vec_pend[g] = |hit;
    end
  endgenerate

  assign srv_lvl = (depth_reg == 2'h0) ? SRV_RESET : srv_stack_reg[depth_reg - 2'h1];
  assign take = ack && grant.valid;

  irq_arbiter u_arb (
    .vec_pend(vec_pend),
    .vec_hi(vec_hi),
    .srv_lvl(srv_lvl),
    .grant_ok(arb_ok),
    .grant_vec(arb_vec),
    .grant_lvl(arb_lvl)
  );

  // pending sources latch; new event wins over the acknowledge clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src_pend_reg <= '0;
    end else if (clk_en) begin
      for (int s = 0; s < NUM_SOURCES; s++) begin
        if (src_req[s]) begin
          src_pend_reg[s] <= 1'b1; // RQ12
        end else if (take && SRC_VEC_MAP[s*VEC_W +: VEC_W] == grant.vec) begin
          src_pend_reg[s] <= 1'b0;
        end
      end
    end
  end

  // service level stack for nesting
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      depth_reg <= 2'h0;
      for (int i = 0; i < 3; i++) srv_stack_reg[i] <= LVL_NONE;
    end else if (clk_en) begin
      if (take && depth_reg != 2'h3) begin
        srv_stack_reg[depth_reg] <= grant.lvl; // RQ1
        depth_reg <= depth_reg + 2'h1;
      end else if (reti && depth_reg != 2'h0) begin
        depth_reg <= depth_reg - 2'h1;
      end
    end
  end

  // registered grant toward the core; dropped on acknowledge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      grant <= '0;
    end else if (clk_en) begin
      grant.valid <= arb_ok && !take && mode == MODE_RUN; // RQ2
      grant.vec <= arb_vec;
      grant.lvl <= arb_lvl;
      grant.addr <= VEC_BASE + 20'(arb_vec) * VEC_STEP;
    end
  end

  // wake sources of the current mode
  always_comb begin
    case (mode)
      MODE_HALT: wake_mask = '1; // RQ7
      MODE_HOLD: wake_mask = HOLD_WAKE_MASK; // RQ9
      MODE_XHOLD: wake_mask = XHOLD_WAKE_MASK; // RQ11
      default: wake_mask = '0;
    endcase
  end
  assign wake = |(src_req & wake_mask);

  // standby mode sequencer; reset covers reset-pin release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= MODE_RUN;
      xtal_keep_reg <= 1'b1;
    end else if (clk_en) begin
      case (mode)
        MODE_RUN: begin
          if (enter_hold) begin
            mode <= MODE_HOLD;
          end else if (enter_xhold) begin
            mode <= MODE_XHOLD;
            xtal_keep_reg <= osc.xtal_run; // RQ10
          end else if (enter_halt) begin
            mode <= MODE_HALT;
          end
        end
        MODE_HALT, MODE_HOLD, MODE_XHOLD: begin
          if (wake) mode <= MODE_RUN; // RQ7 RQ9 RQ11
        end
        default: mode <= MODE_RUN;
      endcase
    end
  end

  // clock and activity enables follow the mode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc <= '1;
      cpu_run <= 1'b1;
      periph_run <= 1'b1;
      remote_run <= 1'b1;
    end else if (clk_en) begin
      case (mode)
        MODE_HALT: begin
          osc <= '1; // RQ6
          cpu_run <= 1'b0;
          periph_run <= 1'b1;
          remote_run <= 1'b1;
        end
        MODE_HOLD: begin
          osc <= '0; // RQ8
          cpu_run <= 1'b0;
          periph_run <= 1'b0;
          remote_run <= 1'b0;
        end
        MODE_XHOLD: begin
          osc <= '{pll_run: 1'b0, ceramic_oscillator_run: 1'b0,
                   internal_rc_oscillator_run: 1'b0, xtal_run: xtal_keep_reg}; // RQ10
          cpu_run <= 1'b0;
          periph_run <= 1'b0;
          remote_run <= 1'b1;
        end
        default: begin
          osc <= '1;
          cpu_run <= 1'b1;
          periph_run <= 1'b1;
          remote_run <= 1'b1;
        end
      endcase
    end
  end

  // checks
  property p_no_grant_at_or_below;
    @(posedge ref_clk) disable iff (!rst_b) grant.valid |-> grant.lvl > $past(srv_lvl);
  endproperty
  a_no_grant_at_or_below: assert property (p_no_grant_at_or_below) else $error("grant not above service level"); // RQ1

  property p_grant_smallest;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && arb_ok && vec_pend[0] && vec_hi[0]) |=> grant.vec == 4'h0;
  endproperty
  a_grant_smallest: assert property (p_grant_smallest) else $error("wrong priority"); // RQ2

  property p_addr_map;
    @(posedge ref_clk) disable iff (!rst_b) grant.valid |-> grant.addr == VEC_BASE + 20'(grant.vec) * VEC_STEP;
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("vector address wrong"); // RQ3

  sequence s_enter_hold;
    clk_en && mode == MODE_RUN && enter_hold;
  endsequence
  property p_hold_stops;
    @(posedge ref_clk) disable iff (!rst_b)
      s_enter_hold ##1 (clk_en && !wake) |=> osc == '0 && !periph_run;
  endproperty
  a_hold_stops: assert property (p_hold_stops) else $error("hold left clocks running"); // RQ8

  property p_halt_keeps;
    @(posedge ref_clk) disable iff (!rst_b) (mode == MODE_HALT && clk_en) |=> osc == '1 && periph_run;
  endproperty
  a_halt_keeps: assert property (p_halt_keeps) else $error("halt stopped clocks"); // RQ6

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_b) (clk_en && mode != MODE_RUN && wake) |=> mode == MODE_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("standby did not end"); // RQ7

  property p_hold_ignores;
    @(posedge ref_clk) disable iff (!rst_b)
      (clk_en && mode == MODE_HOLD && !(|(src_req & HOLD_WAKE_MASK))) |=> mode == MODE_HOLD;
  endproperty
  a_hold_ignores: assert property (p_hold_ignores) else $error("hold woke wrongly"); // RQ9

  property p_xhold_remote;
    @(posedge ref_clk) disable iff (!rst_b) (clk_en && mode == MODE_XHOLD) |=> remote_run && !osc.pll_run;
  endproperty
  a_xhold_remote: assert property (p_xhold_remote) else $error("xhold enables wrong"); // RQ10

  property p_post;
    @(posedge ref_clk) disable iff (!rst_b) (clk_en && src_req[S_BTMR]) |=> src_pend_reg[S_BTMR];
  endproperty
  a_post: assert property (p_post) else $error("request lost"); // RQ12

endmodule : irq_standby

// ### core_model.sv
`timescale 1ns/100ps
module core_model
  import irq_standby_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire grant_s grant,
  input wire logic take,
  input wire logic hold_svc,
  output logic ack,
  output logic reti
);
  logic [1:0] depth_reg;
  // one-cycle ack of a standing grant
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) ack <= 1'b0;
    else ack <= grant.valid && take && !ack;
  end
  // return from service once released, one level per pulse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reti <= 1'b0;
      depth_reg <= 2'h0;
    end else begin
      // never return in the cycle an acknowledge is launched
      reti <= depth_reg != 2'h0 && !hold_svc && !reti && !ack && !(grant.valid && take);
      depth_reg <= depth_reg + 2'(ack) - 2'(reti);
    end
  end
endmodule : core_model

// ### irq_standby_tb.sv
`timescale 1ns/100ps
module irq_standby_tb;
  import irq_standby_pkg::*;
  logic ref_clk, rst_b, ack, reti, take, hold_svc, clk_en;
  logic [NUM_SOURCES-1:0] src_req;
  logic [NUM_VECTORS-1:0] vec_hi;
  logic [2:0] cmd;
  grant_s grant;
  osc_s osc;
  logic cpu_run, periph_run, remote_run;
  standby_mode_e mode;
  int error_cnt, n_tests;
  // source, high level, vector, address
  int rows [12][4] = '{'{S_PIN_A, 1, 0, 20'h00003}, '{S_PIN_B, 1, 1, 20'h0000B},
    '{S_PIN_C, 1, 2, 20'h00013}, '{S_T0L, 0, 2, 20'h00013}, '{S_GRP_E, 1, 2, 20'h00013},
    '{S_USB_ACT, 0, 2, 20'h00013}, '{S_RMT, 1, 2, 20'h00013}, '{S_SSP_A, 1, 6, 20'h00033},
    '{S_USB_RST, 0, 6, 20'h00033}, '{S_USB_SUSP, 1, 6, 20'h00033},
    '{S_UART_RX, 0, 6, 20'h00033}, '{S_PWM1, 0, 9, 20'h0004B}};
  irq_standby dut (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .src_req(src_req),
    .vec_hi(vec_hi), .ack(ack), .reti(reti), .enter_halt(cmd[0]), .enter_xhold(cmd[1]),
    .enter_hold(cmd[2]), .grant(grant), .osc(osc), .cpu_run(cpu_run),
    .periph_run(periph_run), .remote_run(remote_run), .mode(mode));
  core_model core (.ref_clk(ref_clk), .rst_b(rst_b), .grant(grant), .take(take),
    .hold_svc(hold_svc), .ack(ack), .reti(reti));
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task give_verdict;
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task pulse(input logic [NUM_SOURCES-1:0] m);
    @(posedge ref_clk) src_req <= m;
    @(posedge ref_clk) src_req <= '0;
  endtask : pulse
  // bounded wait for a grant, then its vector
  task wait_g(input int v);
    int i;
    #1;
    i = 0;
    while (grant.valid !== 1'b1 && i < 12) begin
      wt(1);
      i++;
    end
    chk("grant vec", {grant.valid, grant.vec}, {1'b1, 4'(v)});
  endtask : wait_g
  task go(input logic [2:0] c);
    @(posedge ref_clk) cmd <= c;
    @(posedge ref_clk) cmd <= 3'h0;
    wt(3);
  endtask : go
  task serve;
    @(posedge ref_clk) take <= 1'b1;
    wt(16);
    @(posedge ref_clk) take <= 1'b0;
  endtask : serve
  task stby(input standby_mode_e m, input logic [3:0] o, input logic [2:0] runs);
    chk("mode", mode, m);
    chk("osc", osc, o);
    chk("runs", {cpu_run, periph_run, remote_run}, runs);
  endtask : stby
  // watchdog
  initial begin
    wt(4000);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rst_b, src_req, vec_hi, cmd, hold_svc} = '0;
    {take, clk_en} = 2'h3;
    wt(16);
    stby(MODE_RUN, 4'hF, 3'h7);
    chk("valid", grant.valid, 1'b0);
    @(posedge ref_clk) rst_b <= 1'b1;
    // mapping, addresses and levels
    foreach (rows[r]) begin
      @(posedge ref_clk) vec_hi <= rows[r][1] ? '1 : '0;
      pulse(28'h1 << rows[r][0]);
      wait_g(rows[r][2]);
      chk("addr", grant.addr, rows[r][3]);
      chk("lvl", grant.lvl, !rows[r][1] ? LVL_LOW : rows[r][2] < 2 ? LVL_TOP : LVL_HIGH);
      wt(8);
    end
    // simultaneous requests
    @(posedge ref_clk) vec_hi <= '0;
    pulse((28'h1 << S_ADC) | (28'h1 << S_T0H));
    wait_g(4);
    wt(20);
    @(posedge ref_clk) vec_hi <= 10'h100;
    pulse((28'h1 << S_ADC) | (28'h1 << S_T0H));
    wait_g(8);
    wt(20);
    // nesting under a low service
    @(posedge ref_clk) vec_hi <= '0;
    hold_svc <= 1'b1;
    pulse(28'h1 << S_T0H);
    wait_g(4);
    pulse(28'h1 << S_GRP_F);
    wt(6);
    chk("valid", grant.valid, 1'b0);
    @(posedge ref_clk) vec_hi <= 10'h100;
    pulse(28'h1 << S_T6);
    wait_g(8);
    wt(4);
    @(posedge ref_clk) hold_svc <= 1'b0;
    wait_g(3);
    wt(20);
    // standby modes
    @(posedge ref_clk) take <= 1'b0;
    vec_hi <= '0;
    go(3'h1);
    stby(MODE_HALT, 4'hF, 3'h3);
    pulse(28'h1 << S_T6);
    wt(3);
    chk("mode", mode, MODE_RUN);
    wait_g(8);
    serve();
    go(3'h4);
    stby(MODE_HOLD, 4'h0, 3'h0);
    pulse(28'h1 << S_BTMR);
    wt(3);
    chk("mode", mode, MODE_HOLD);
    // port 0 raised to high so it outranks the still pending base timer
    @(posedge ref_clk) vec_hi <= 10'h200;
    pulse(28'h1 << S_PORT0);
    wt(3);
    chk("mode", mode, MODE_RUN);
    wait_g(9);
    serve();
    go(3'h2);
    stby(MODE_XHOLD, 4'h1, 3'h1);
    pulse(28'h1 << S_BTMR);
    wt(3);
    chk("mode", mode, MODE_RUN);
    wait_g(3);
    serve();
    go(3'h4);
    pulse(28'h1 << S_GRP_F);
    wt(3);
    chk("mode", mode, MODE_RUN);
    wait_g(3);
    go(3'h4);
    // frozen clock enable: a wake source must not end hold
    @(posedge ref_clk) clk_en <= 1'b0;
    pulse(28'h1 << S_GRP_F);
    wt(2);
    chk("mode", mode, MODE_HOLD);
    @(posedge ref_clk) clk_en <= 1'b1;
    // reset in mid-run ends hold and drops pending requests
    @(posedge ref_clk) rst_b <= 1'b0;
    wt(2);
    @(posedge ref_clk) rst_b <= 1'b1;
    wt(2);
    stby(MODE_RUN, 4'hF, 3'h7);
    chk("valid", grant.valid, 1'b0);
    give_verdict();
  end
endmodule : irq_standby_tb
